// *** core/adc_ctrl_pkg.sv ***
// adc_ctrl_pkg: shared constants and types for the converter control block
// assumes: one 200 MHz system clock, asynchronous active-high reset
package adc_ctrl_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int RESULT_W   = 12;            // conversion result width
  localparam int CTRL_W     = 8;             // divide and sample-time control width
  localparam int MODE_W     = 4;             // operating mode width
  localparam int FIFO_DEPTH = 16;            // result buffer depth
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;       // 200 MHz system clock
  localparam int CAL_TIME_NS   = 10000;      // power-up calibration time
  localparam int CAL_CYCLES    = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000; // result after reset
  // ------------------------------------------------------------
  // converter sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET,                                // held in converter reset
    ST_CAL,                                  // power-up calibration
    ST_IDLE,                                 // ready for a start
    ST_SAMPLE,                               // acquiring the input
    ST_CONVERT,                              // successive approximation
    ST_DONE                                  // result push
  } conv_state_t;
endpackage : adc_ctrl_pkg

// *** core/result_fifo.sv ***
// result_fifo: synchronous valid/ready buffer for conversion results
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 12,                  // word width
  parameter int DEPTH = 16                   // word count, power of two
) (
  input  wire logic             i_ref_clk,   // system clock
  input  wire logic             i_rst,       // async reset, active high
  input  wire logic             i_in_valid,  // write request
  output logic                  o_in_ready,  // space available
  input  wire logic [WIDTH-1:0] i_in_data,   // write data
  output logic                  o_out_valid, // word available
  input  wire logic             i_out_ready, // reader takes word
  output logic [WIDTH-1:0]      o_out_data   // head word
);
  localparam int AW = $clog2(DEPTH);         // address width, one bit narrower than the wrap-bit pointers
  // refuse depths the wrap-bit pointers cannot serve
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("result_fifo: DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];           // storage array
  logic [AW:0]      wp_r, wp_nxt;            // write pointer with wrap bit
  logic [AW:0]      rp_r, rp_nxt;            // read pointer with wrap bit
  logic             push, pop;               // accepted handshakes
  // ------------------------------------------------------------
  // flags and next pointers
  // ------------------------------------------------------------
  always_comb begin
    o_in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);  // honest full
    o_out_valid = wp_r != rp_r;                     // honest empty
    o_out_data  = mem_r[rp_r[AW-1:0]];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wp_nxt      = wp_r + (AW+1)'(push);
    rp_nxt      = rp_r + (AW+1)'(pop);
  end
  // pointer registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  // storage has no reset; only written words are ever read
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= i_in_data;
    end
  end
endmodule // result_fifo
`default_nettype wire

// *** core/adc_ctrl.sv ***
// adc_ctrl: digital sequencer of a successive-approximation converter
// assumes: control inputs come from logic on i_ref_clk, analog comparator
// decision arrives on a pin and is synchronised here
// Contract
// RULE1 - fabric resets block after power-up and programming
// RULE2 - power-down stops comparator and conversions
// RULE3 - fabric should keep power-down deasserted
// RULE4 - converter reset holds converter, disables quad inputs
// RULE5 - busy high exactly while converting
// RULE6 - calibrate high during power-up calibration only; the code also holds it high while in converter reset (ST_RESET)
// RULE7 - result valid marks a valid twelve-bit result; in 8-bit mode (i_mode bit0) the code converts only bits 7:0
// RULE8 - sampling high only during acquisition
// RULE9 - one-cycle start while idle begins a conversion
// RULE10 - divide control and sample time set timing
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int CAL_COUNT = adc_ctrl_pkg::CAL_CYCLES  // calibration length in clocks
) (
  input  wire logic                              i_ref_clk,                // system clock
  input  wire logic                              i_rst,                    // async reset
  input  wire logic                              i_converter_reset,        // converter reset
  input  wire logic                              i_comparator_power_down,  // comparator off
  input  wire logic                              i_conversion_start,       // start pulse
  input  wire logic [adc_ctrl_pkg::MODE_W-1:0]   i_mode,                   // mode, bit0 8-bit
  input  wire logic [adc_ctrl_pkg::CTRL_W-1:0]   i_clock_divide_ctrl,      // divider
  input  wire logic [adc_ctrl_pkg::CTRL_W-1:0]   i_sample_time_ctrl,       // acquisition
  input  wire logic                              i_internal_temp_strobe,   // temp strobe
  input  wire logic                              i_comp_in,                // comparator pin
  input  wire logic                              i_result_ready,           // reader takes
  output logic                                   o_busy,                   // converting
  output logic                                   o_calibrate,              // calibrating
  output logic                                   o_sample,                 // acquiring
  output logic                                   o_result_valid,           // result there
  output logic [adc_ctrl_pkg::RESULT_W-1:0]      o_result,                 // result word
  output logic                                   o_quad_enable,            // quad inputs on
  output logic                                   o_comp_enable,            // comparator on
  output logic                                   o_temp_strobe             // strobe to quad
);
  import adc_ctrl_pkg::*;
  // the calibration counter is sixteen bits wide
  if (CAL_COUNT < 1 || CAL_COUNT > 65535) begin : g_cal_check
    $error("adc_ctrl: CAL_COUNT out of range");
  end
  // ------------------------------------------------------------
  // comparator pin synchroniser: three stages, second and third agree
  // ------------------------------------------------------------
  logic [2:0] comp_sync_r, comp_sync_nxt;    // synchroniser chain
  logic       comp_bit_r, comp_bit_nxt;      // filtered decision
  always_comb begin
    comp_sync_nxt = {comp_sync_r[1:0], i_comp_in};
    comp_bit_nxt  = (comp_sync_r[1] == comp_sync_r[2]) ? comp_sync_r[2] : comp_bit_r;
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      comp_sync_r <= 3'h0;
      comp_bit_r  <= 1'b0;
    end else begin
      comp_sync_r <= comp_sync_nxt;
      comp_bit_r  <= comp_bit_nxt;
    end
  end
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  conv_state_t          st_r, st_nxt;        // sequencer state
  logic [15:0]          cnt_r, cnt_nxt;      // calibration / sample counter
  logic [CTRL_W:0]      div_r, div_nxt;      // conversion clock divider
  logic [3:0]           bit_r, bit_nxt;      // bit under test
  logic [RESULT_W-1:0]  sar_r, sar_nxt;      // approximation register
  logic                 push;                // result into buffer
  logic                 fifo_ready;          // buffer has room
  logic                 conv_tick;           // one conversion clock
  logic                 fifo_valid;          // buffer head valid
  logic [RESULT_W-1:0]  fifo_data;           // buffer head word
  logic                 fifo_take;           // head moves into output stage
  // divider wraps after clock_divide_ctrl+1 system clocks
  always_comb begin
    conv_tick = (div_r == {1'b0, i_clock_divide_ctrl}); // RULE10
  end
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    div_nxt = conv_tick ? '0 : div_r + 1'b1;
    bit_nxt = bit_r;
    sar_nxt = sar_r;
    push    = 1'b0;
    case (st_r)
      // held until reset is released
      ST_RESET: begin
        st_nxt  = ST_CAL;
        cnt_nxt = 16'(CAL_COUNT - 1);
      end
      // power-up calibration, counted on system clocks
      ST_CAL: begin
        if (cnt_r == 16'h0000) begin
          st_nxt = ST_IDLE;                                   // RULE6
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      // start taken only while idle and comparator powered
      ST_IDLE: begin
        if (i_conversion_start && !i_comparator_power_down) begin // RULE9 RULE2
          st_nxt  = ST_SAMPLE;
          cnt_nxt = {8'h00, i_sample_time_ctrl};              // RULE10
        end
      end
      // acquisition lasts sample_time_ctrl+1 system clocks
      ST_SAMPLE: begin
        if (cnt_r == 16'h0000) begin
          st_nxt  = ST_CONVERT;
          div_nxt = '0;
          bit_nxt = i_mode[0] ? 4'h7 : 4'(RESULT_W - 1);
          sar_nxt = '0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      // one result bit per conversion clock, msb first
      ST_CONVERT: begin
        if (conv_tick) begin
          sar_nxt[bit_r] = comp_bit_r;
          if (bit_r == 4'h0) begin
            st_nxt = ST_DONE;
          end else begin
            bit_nxt = bit_r - 1'b1;
          end
        end
      end
      // waits here when the buffer is full: back-pressure stalls starts
      ST_DONE: begin
        if (fifo_ready) begin
          push   = 1'b1;                                      // RULE7
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_RESET;
    endcase
    // power-down aborts work but keeps calibration state; a stalled result is dropped
    if (i_comparator_power_down &&
        (st_r == ST_SAMPLE || st_r == ST_CONVERT || st_r == ST_DONE)) begin
      st_nxt = ST_IDLE;                                       // RULE2
    end
    if (i_converter_reset) begin
      st_nxt = ST_RESET;                                      // RULE4
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r  <= ST_RESET;
      cnt_r <= 16'h0000;
      div_r <= '0;
      bit_r <= 4'h0;
      sar_r <= RESULT_RST;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      sar_r <= sar_nxt;
    end
  end
  // ------------------------------------------------------------
  // result buffer
  // ------------------------------------------------------------
  result_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst || i_converter_reset),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (sar_r),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_take),
    .o_out_data  (fifo_data)
  );
  // ------------------------------------------------------------
  // registered outputs; busy, calibrate and sample are computed from the next state so they track it
  // ------------------------------------------------------------
  logic busy_nxt, cal_nxt, samp_nxt, val_nxt, qen_nxt, cen_nxt, ts_nxt; // next outputs
  logic [RESULT_W-1:0] res_nxt;                                          // next result
  logic pop_now;                                                         // head taken
  always_comb begin
    pop_now  = o_result_valid && i_result_ready;
    busy_nxt = (st_nxt == ST_SAMPLE) || (st_nxt == ST_CONVERT) || (st_nxt == ST_DONE); // RULE5
    cal_nxt  = (st_nxt == ST_CAL) || (st_nxt == ST_RESET);                             // RULE6
    samp_nxt = (st_nxt == ST_SAMPLE);                                                  // RULE8
    qen_nxt  = !i_converter_reset;                                                     // RULE4
    cen_nxt  = !i_comparator_power_down;                                               // RULE2
    ts_nxt   = i_internal_temp_strobe && !i_converter_reset;
    // the head leaves the buffer when it moves into the output stage, so no
    // word is shown twice; a taken word is replaced by the next one at once
    fifo_take = fifo_valid && (!o_result_valid || pop_now);
    val_nxt  = !i_converter_reset && ((o_result_valid && !pop_now) || fifo_valid); // RULE7
    res_nxt  = (o_result_valid && !pop_now) ? o_result : fifo_data;
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy         <= 1'b0;
      o_calibrate    <= 1'b1;
      o_sample       <= 1'b0;
      o_result_valid <= 1'b0;
      o_result       <= RESULT_RST;
      o_quad_enable  <= 1'b0;
      o_comp_enable  <= 1'b0;
      o_temp_strobe  <= 1'b0;
    end else begin
      o_busy         <= busy_nxt;
      o_calibrate    <= cal_nxt;
      o_sample       <= samp_nxt;
      o_result_valid <= val_nxt;
      o_result       <= res_nxt;
      o_quad_enable  <= qen_nxt;
      o_comp_enable  <= cen_nxt;
      o_temp_strobe  <= ts_nxt;
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // helper for the sample-length check: cycles spent with o_sample high
  logic [CTRL_W:0] samp_len_r, samp_len_nxt; // sampling cycle count
  always_comb begin
    samp_len_nxt = o_sample ? samp_len_r + 1'b1 : '0;
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      samp_len_r <= '0;
    end else begin
      samp_len_r <= samp_len_nxt;
    end
  end
  chk_busy_state: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE5
    o_busy == (st_r == ST_SAMPLE || st_r == ST_CONVERT || st_r == ST_DONE))
    else $error("busy does not follow conversion");
  chk_sample_in_busy: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE8
    o_sample |-> o_busy) else $error("sampling outside a conversion");
  chk_reset_quad: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE4
    i_converter_reset |=> !o_quad_enable && !o_busy) else $error("reset did not hold converter");
  chk_pdown_stop: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE2
    i_comparator_power_down |=> !o_busy && !o_comp_enable) else $error("power-down kept running");
  chk_cal_done: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE6
    $fell(o_calibrate) |-> $past(st_r) == ST_CAL) else $error("calibrate fell outside calibration");
  chk_start_busy: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE9
    (st_r == ST_IDLE && i_conversion_start && !i_comparator_power_down && !i_converter_reset)
    |=> o_busy && o_sample) else $error("start not taken");
  chk_sample_len: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE10
    ($fell(o_sample) && o_busy) |-> samp_len_r == ({1'b0, i_sample_time_ctrl} + 1'b1))
    else $error("sample time not honoured");
  chk_valid_stable: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE7
    (o_result_valid && !i_result_ready && !i_converter_reset) |=> o_result_valid
    && $stable(o_result)) else $error("result changed before it was taken");
  cov_conversion: cover property (@(posedge i_ref_clk) disable iff (i_rst) push);
  cov_calibrated: cover property (@(posedge i_ref_clk) disable iff (i_rst) $fell(o_calibrate));
  cov_full_stall: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    st_r == ST_DONE && !fifo_ready);
endmodule // adc_ctrl
`default_nettype wire

// *** verification/fabric_partner.sv ***
// fabric_partner: comparator pin and result consumer beside the converter
// assumes: single clock, the bench sets the level and the consumer's will
`timescale 1ns/1ps
`default_nettype none
module fabric_partner (
  input  wire logic i_ref_clk,      // system clock
  input  wire logic i_comp_enable,  // comparator powered
  input  wire logic i_level,        // decision to present
  input  wire logic i_take,         // consumer willing
  output logic      o_comp_in,      // decision pin
  output logic      o_result_ready  // consumer ready
);
  // ----------------------------------------------------------
  // comparator pin
  // ----------------------------------------------------------
  logic toggle_r = 1'b0;            // wiggle for an unpowered pin
  // toggles so an undriven pin never looks like a steady decision
  always_ff @(negedge i_ref_clk) begin
    toggle_r <= ~toggle_r;
  end
  assign o_comp_in = i_comp_enable ? i_level : toggle_r;
  // consumer only takes words while the bench allows it
  assign o_result_ready = i_take;
endmodule // fabric_partner
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: scenario tasks for the converter control block
// assumes: inputs move at the falling edge, shortened calibration
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_ctrl_pkg::*;
  // ----------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------
  localparam int                CAL_SIM = 4;      // short calibration
  localparam logic [CTRL_W-1:0] DIV     = 8'h01;  // bit every 2 clocks
  localparam logic [CTRL_W-1:0] STIME   = 8'h02;  // 3-clock acquisition
  logic i_ref_clk = 1'b0, i_rst = 1'b1, cr = 1'b0, pd = 1'b0, st = 1'b0;
  logic ts = 1'b0, lvl = 1'b0, take = 1'b0, comp, rdy;
  logic [MODE_W-1:0] mode = 4'h0;
  logic busy, cal, smp, rv, quad, compen, tso;
  logic [RESULT_W-1:0] res;
  int error_cnt = 0, samples_checked = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  adc_ctrl #(.CAL_COUNT(CAL_SIM)) adc_ctrl_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_converter_reset(cr), .i_comparator_power_down(pd), .i_conversion_start(st),
    .i_mode(mode), .i_clock_divide_ctrl(DIV), .i_sample_time_ctrl(STIME),
    .i_internal_temp_strobe(ts), .i_comp_in(comp), .i_result_ready(rdy),
    .o_busy(busy), .o_calibrate(cal), .o_sample(smp), .o_result_valid(rv),
    .o_result(res), .o_quad_enable(quad), .o_comp_enable(compen), .o_temp_strobe(tso));
  fabric_partner fabric_partner_i (.i_ref_clk(i_ref_clk), .i_comp_enable(compen),
    .i_level(lvl), .i_take(take), .o_comp_in(comp), .o_result_ready(rdy));
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic chk1(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkw(string nm, logic [RESULT_W-1:0] e, logic [RESULT_W-1:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a wait that runs out ends the run as a mismatch
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v) begin
      if (++n > lim) begin
        error_cnt++;
        $display("ERROR wait expected %b seen %b", v, s);
        complete_run();
      end
      tick();
    end
  endtask
  task automatic pulse_start();
    wait_for(busy, 1'b0, 400);
    wait_for(cal, 1'b0, 400);
    st = 1'b1;
    tick();
    st = 1'b0;
  endtask
  task automatic get_result(logic [RESULT_W-1:0] e);
    wait_for(rv, 1'b1, 400);
    chkw("result", e, res);
    take = 1'b1;
    tick();
    take = 1'b0;
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic test_reset();
    chk1("cal in reset", 1'b1, cal);
    chk1("busy in reset", 1'b0, busy);
    i_rst = 1'b0;
    tick(CAL_SIM);
    chk1("cal running", 1'b1, cal);
    chk1("quad on", 1'b1, quad);
    wait_for(cal, 1'b0, 3);
    $display("test reset done");
  endtask
  task automatic test_convert(logic [MODE_W-1:0] m, logic l, logic [RESULT_W-1:0] e);
    int n;
    mode = m;
    lvl = l;
    pulse_start();
    chk1("busy", 1'b1, busy);
    chk1("sample", 1'b1, smp);
    n = 0;
    while (smp === 1'b1 && n < 300) begin
      n++;
      tick();
    end
    chkw("sample len", 12'(STIME) + 12'h001, 12'(n));
    chk1("busy after sample", 1'b1, busy);
    get_result(e);
    tick(3);
    chk1("busy idle", 1'b0, busy);
    $display("test convert %h done", e);
  endtask
  task automatic test_refuse();
    lvl = 1'b1;
    mode = 4'h0;
    pulse_start();
    tick(2);
    st = 1'b1;
    tick();
    st = 1'b0;
    get_result(12'hfff);
    tick(60);
    chk1("no second result", 1'b0, rv);
    $display("test refuse done");
  endtask
  task automatic test_power_down();
    pulse_start();
    pd = 1'b1;
    tick(5);
    chk1("pd busy", 1'b0, busy);
    chk1("pd comp", 1'b0, compen);
    st = 1'b1;
    tick();
    st = 1'b0;
    tick();
    chk1("pd start refused", 1'b0, busy);
    pd = 1'b0;
    tick(40);
    chk1("pd no result", 1'b0, rv);
    chk1("comp back", 1'b1, compen);
    $display("test power down done");
  endtask
  task automatic test_conv_reset();
    cr = 1'b1;
    ts = 1'b1;
    tick(3);
    chk1("cr quad", 1'b0, quad);
    chk1("cr cal", 1'b1, cal);
    chk1("cr strobe gated", 1'b0, tso);
    cr = 1'b0;
    wait_for(cal, 1'b0, CAL_SIM + 4);
    chk1("cr quad back", 1'b1, quad);
    chk1("strobe passes", 1'b1, tso);
    ts = 1'b0;
    $display("test converter reset done");
  endtask
  task automatic test_fifo();
    int n, k;
    lvl = 1'b1;
    mode = 4'h0;
    repeat (FIFO_DEPTH + 1) pulse_start();
    tick(3);
    pulse_start();
    tick(80);
    chk1("full stalls", 1'b1, busy);
    take = 1'b1;
    n = 0;
    for (k = 0; k < 200; k++) begin
      if (rv === 1'b1) begin
        n++;
        chkw("drained", 12'hfff, res);
      end
      tick();
    end
    take = 1'b0;
    chkw("word count", 12'(FIFO_DEPTH + 2), 12'(n));
    chk1("empty", 1'b0, rv);
    $display("test fifo done");
  endtask
  initial begin
    tick(2);
    test_reset();
    test_convert(4'h0, 1'b1, 12'hfff);
    test_convert(4'h0, 1'b0, 12'h000);
    test_convert(4'h1, 1'b1, 12'h0ff);
    test_refuse();
    test_power_down();
    test_conv_reset();
    test_convert(4'h0, 1'b1, 12'hfff);
    test_fifo();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
